//--- verification/hivc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***
// host cpu bus model
// ***
module hivc_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	input  wire logic       data_ack_strobe_n,
	output var  logic       cs_n,
	output var  logic       rd_n,
	output var  logic       wr_n,
	output var  logic       irq_ack_strobe_n,
	output var  logic [6:0] addr,
	output var  logic [7:0] data_in
);
	initial begin
		{cs_n, rd_n, wr_n, irq_ack_strobe_n} = 4'hF;
		addr = 7'h55;
		data_in = 8'hA5;
	end
	// k 0 read, 1 write, 2 vector fetch; strobe held until acknowledge so
	// even the slowest delay code is never cut short
	task automatic xfer(input [1:0] k, input [6:0] a, input [7:0] d,
		output [7:0] q, output int w);
		int n;
		@(posedge clk);
		addr <= a;
		data_in <= d;
		cs_n <= k[1];
		rd_n <= k != 2'd0;
		wr_n <= k != 2'd1;
		irq_ack_strobe_n <= !k[1];
		n = 0;
		w = 0;
		do begin
			@(negedge clk);
			n++;
			w += data_oe === 1'b1 && data_ack_strobe_n === 1'b1;
		end while (data_ack_strobe_n !== 1'b0 && n < 30);
		q = data_out;
		if (n >= 30) w = -1;
		@(posedge clk);
		{cs_n, rd_n, wr_n, irq_ack_strobe_n} <= 4'hF;
		// released lines flip so a stale value never looks live
		addr <= ~a;
		data_in <= ~d;
		repeat (4) @(posedge clk);
	endtask
endmodule // hivc_host_model
`default_nettype wire

//--- verification/hivc_host_port_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "hivc_regs.vh"
// ***
// host port checks
// ***
module hivc_props (
	input  wire logic                    clk,
	input  wire logic                    reset,
	input  wire logic                    soft_reset,
	input  wire logic                    rd_n,
	input  wire logic                    wr_n,
	input  wire logic                    irq_ack_strobe_n,
	input  wire logic                    cs_n,
	input  wire logic [`HIVC_ADDR_W-1:0] addr,
	input  wire logic [7:0]              data_out,
	input  wire logic [7:0]              mode_out,
	input  wire logic [7:0]              clock_sel_out,
	input  wire logic [7:0]              irq_mask_out,
	input  wire logic                    data_oe,
	input  wire logic                    data_ack_strobe_n,
	input  wire logic                    extended_mode,
	input  wire logic                    rx_enable,
	input  wire logic                    tx_enable
);
	// one clock domain, hard reset disables every check
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	chk_rst_legacy: assert property (
		$past(reset) |-> !extended_mode && !rx_enable && !tx_enable)
		else $error("not idle after reset");
	chk_rst_format: assert property (
		$past(reset) |-> mode_out == `HIVC_MODE_RST &&
		clock_sel_out == `HIVC_CSEL_RST && irq_mask_out == `HIVC_IMASK_RST)
		else $error("bad line settings after reset");
	chk_soft_idle: assert property (
		soft_reset [*4] |=> !extended_mode && !rx_enable && !tx_enable &&
		mode_out == `HIVC_MODE_RST) else $error("soft reset ignored");
	chk_oe_cause: assert property (
		$rose(data_oe) |-> $past(!rd_n && !cs_n || !irq_ack_strobe_n, 2))
		else $error("bus driven without strobe");
	chk_ack_gap: assert property (
		$rose(data_oe) |-> data_ack_strobe_n ##[1:3] !data_ack_strobe_n)
		else $error("ack delay out of range");
	chk_out_hold: assert property (
		data_oe && $past(data_oe) |-> $stable(data_out))
		else $error("data moved while driven");
	chk_bus_free: assert property (
		(rd_n && wr_n && irq_ack_strobe_n) [*4] |=>
		!data_oe && data_ack_strobe_n) else $error("bus not released");
	chk_ext_cause: assert property (
		$rose(extended_mode) |-> $past(addr, 2) > `HIVC_LEGACY_TOP &&
		$past(!cs_n && !(rd_n && wr_n), 2)) else $error("bad extended set");
endmodule // hivc_props
bind hivc_host_port hivc_props u_props (.clk, .reset, .soft_reset, .rd_n,
	.wr_n, .irq_ack_strobe_n, .cs_n, .addr, .data_out, .mode_out,
	.clock_sel_out, .irq_mask_out, .data_oe, .data_ack_strobe_n,
	.extended_mode, .rx_enable, .tx_enable);
`default_nettype wire

//--- verification/tb_host_init_and_vector_config.sv
`timescale 1ns/1ps
`default_nettype none
// ***
// bench top
// ***
module tb_host_init_and_vector_config;
	logic        clk = 1'b0, reset = 1'b1, soft_reset = 1'b0;
	logic        irq_rx_err = 1'b0;
	logic [1:0]  irq_src = 2'd0;
	logic        cs_n, rd_n, wr_n, irq_ack_strobe_n, data_oe;
	logic        data_ack_strobe_n, extended_mode, rx_enable, tx_enable;
	logic [6:0]  addr;
	logic [7:0]  data_in, data_out, mode_out, clock_sel_out, irq_mask_out;
	logic [7:0]  q, b, g, e;
	logic [31:0] seed = 32'hDF282C60;
	int          miscompares = 0, comparisons = 0, w;
	always #20 clk = ~clk;
	hivc_host_port u_dut (.clk, .reset, .soft_reset, .cs_n, .rd_n, .wr_n,
		.irq_ack_strobe_n, .addr, .data_in, .irq_src, .irq_rx_err,
		.data_out, .data_oe, .data_ack_strobe_n, .extended_mode,
		.rx_enable, .tx_enable, .mode_out, .clock_sel_out, .irq_mask_out);
	hivc_host_model u_host (.clk, .data_out, .data_oe, .data_ack_strobe_n,
		.cs_n, .rd_n, .wr_n, .irq_ack_strobe_n, .addr, .data_in);
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
	endfunction
	// channel code is zero in this single-channel build
	function automatic [7:0] vexp(input [1:0] c, input [7:0] v,
		input [1:0] s, input r);
		case (c)
		2'b00: vexp = 8'hFF;
		2'b01: vexp = v;
		2'b10: vexp = {v[7:1], 1'b0};
		default: vexp = {v[7:3], s == 2'd1, s == 2'd1 ? r : s == 2'd2, 1'b0};
		endcase
	endfunction
	task automatic chk(input string nm, input [7:0] got, input [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk("idle", {5'h0, extended_mode, rx_enable, tx_enable}, 8'h0);
		chk("mode", mode_out, 8'h13);
		chk("clksel", clock_sel_out, 8'hBB);
		chk("imask", irq_mask_out, 8'h03);
		// configuration register is the first one touched
		u_host.xfer(2'd0, 7'h66, 8'h00, q, w);
		chk("gcfg rst", q, 8'h00);
		chk("ext", {7'h0, extended_mode}, 8'h01);
		u_host.xfer(2'd1, 7'h02, 8'hE0, q, w);
		chk("enable", {6'h0, rx_enable, tx_enable}, 8'h03);
		$display("reset and enable test done");
		// every control and delay code, every source, random base
		for (int i = 0; i < 32; i++) begin
			seed = lfsr(seed);
			{g, b} = seed[15:0];
			{g[7:6], g[2:1]} = i[3:0];
			irq_src <= i[4:3];
			irq_rx_err <= seed[16] ^ i[2]; // both rx kinds meet code 11
			u_host.xfer(2'd1, 7'h0C, b, q, w);
			u_host.xfer(2'd1, 7'h66, g, q, w);
			u_host.xfer(2'd0, 7'h66, 8'h00, q, w);
			chk("gcfg", q, g & 8'hC6);
			u_host.xfer(2'd2, 7'h00, 8'h00, q, w);
			e = vexp(g[2:1], b, irq_src, irq_rx_err);
			chk("vector", q, e);
			e = g[7] ? 8'h01 : 8'h03 - {7'h0, g[6]};
			chk("ack", w[7:0], e);
			chk("oe free", {7'h0, data_oe}, 8'h00);
		end
		$display("vector test done");
		soft_reset <= 1'b1;
		repeat (6) @(posedge clk);
		soft_reset <= 1'b0;
		@(negedge clk);
		chk("soft", {5'h0, extended_mode, rx_enable, tx_enable}, 8'h0);
		chk("soft mode", mode_out, 8'h13);
		// mode changed only with channel off, legacy set untouched
		seed = lfsr(seed);
		u_host.xfer(2'd1, 7'h00, seed[7:0], q, w);
		@(negedge clk);
		chk("mode wr", mode_out, seed[7:0]);
		chk("legacy", {7'h0, extended_mode}, 8'h00);
		u_host.xfer(2'd0, 7'h66, 8'h00, q, w);
		chk("soft gcfg", q, 8'h00);
		$display("soft reset test done");
		end_sim;
	end
	// hang guard, over ten times the 1500 or so cycles needed
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_sim;
	end
endmodule // tb_host_init_and_vector_config
`default_nettype wire

//--- verilog/hivc_host_port.v
`timescale 1ns/1ps
`default_nettype none
`include "hivc_regs.vh"
module hivc_host_port #(
	parameter CHAN_CODE = 1'b0 // arbitrary single-channel code
) (
	input  wire                     clk,
	input  wire                     reset,
	input  wire                     soft_reset,
	input  wire                     cs_n,
	input  wire                     rd_n,
	input  wire                     wr_n,
	input  wire                     irq_ack_strobe_n,
	input  wire [`HIVC_ADDR_W-1:0]  addr,
	input  wire [7:0]               data_in,
	input  wire [1:0]               irq_src,
	input  wire                     irq_rx_err,
	output reg  [7:0]               data_out,
	output reg                      data_oe,
	output reg                      data_ack_strobe_n,
	output reg                      extended_mode,
	output reg                      rx_enable,
	output reg                      tx_enable,
	output reg  [7:0]               mode_out,
	output reg  [7:0]               clock_sel_out,
	output reg  [7:0]               irq_mask_out
);
	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	reg [4:0] sync1_q, sync2_q;
	reg [`HIVC_ADDR_W-1:0] a1_q, a2_q;
	reg [7:0] d1_q, d2_q;
	// the reset value is the idle level of every pin, so leaving reset
	// never shows a false strobe or a false soft reset
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_q <= `HIVC_SYNC_IDLE;
			sync2_q <= `HIVC_SYNC_IDLE;
			a1_q    <= 7'h00;
			a2_q    <= 7'h00;
			d1_q    <= 8'h00;
			d2_q    <= 8'h00;
		end else begin
			sync1_q <= {irq_ack_strobe_n, wr_n, rd_n, cs_n, soft_reset};
			sync2_q <= sync1_q;
			a1_q    <= addr;
			a2_q    <= a1_q;
			d1_q    <= data_in;
			d2_q    <= d1_q;
		end
	end
	// soft reset is an active-high level; the strobes are active low
	wire srst   = sync2_q[0];
	wire sel    = ~sync2_q[1];
	wire rd_a   = sel & ~sync2_q[2];
	wire wr_a   = sel & ~sync2_q[3];
	wire iack_a = ~sync2_q[4];

	// ****************************************************************
	// cycle tracking
	// ****************************************************************
	reg       busy_q;
	reg [2:0] cnt_q;
	reg [7:0] gcfg_q, mode_q, csel_q, imask_q, vbase_q;
	wire      active = rd_a | wr_a | iack_a;
	wire      start  = active & ~busy_q;

	// delay in whole clocks; half-clock steps round up to one
	function [2:0] ack_delay;
		input [1:0] f;
		begin
			case (f)
			2'b00:   ack_delay = `HIVC_ACK_D00;
			2'b01:   ack_delay = `HIVC_ACK_D01;
			default: ack_delay = `HIVC_ACK_D10; // reserved too
			endcase
		end
	endfunction

	wire [7:0] vec;
	// source and error come from logic on this clock and need no sync
	hivc_vector u_vec (
		.vctl      (gcfg_q[`HIVC_VCTL_HI:`HIVC_VCTL_LO]),
		.vbase     (vbase_q),
		.chan_code (CHAN_CODE[0]),
		.src       (irq_src),
		.rx_err    (irq_rx_err),
		.vector    (vec)
	);

	// register read mux
	reg [7:0] rdata;
	always @* begin
		case (a2_q)
		`HIVC_ADDR_GCFG:  rdata = gcfg_q;
		`HIVC_ADDR_MODE:  rdata = mode_q;
		`HIVC_ADDR_CSEL:  rdata = csel_q;
		`HIVC_ADDR_IMASK: rdata = imask_q;
		`HIVC_ADDR_VBASE: rdata = vbase_q;
		`HIVC_ADDR_STAT:  rdata = {5'h00, extended_mode, tx_enable,
			rx_enable};
		default:          rdata = 8'h00;
		endcase
	end

	// ****************************************************************
	// registers and bus handshake
	// ****************************************************************
	// soft reset is a level from a pin; it clears the same registers as the hard one except cnt_q and data_out
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			gcfg_q            <= `HIVC_GCFG_RST;
			mode_q            <= `HIVC_MODE_RST;
			csel_q            <= `HIVC_CSEL_RST;
			imask_q           <= `HIVC_IMASK_RST;
			vbase_q           <= `HIVC_VBASE_RST;
			extended_mode     <= 1'b0;
			rx_enable         <= 1'b0;
			tx_enable         <= 1'b0;
			busy_q            <= 1'b0;
			cnt_q             <= 3'd0;
			data_out          <= 8'h00;
			data_oe           <= 1'b0;
			data_ack_strobe_n <= 1'b1;
		end else if (srst) begin
			gcfg_q            <= `HIVC_GCFG_RST;
			mode_q            <= `HIVC_MODE_RST;
			csel_q            <= `HIVC_CSEL_RST;
			imask_q           <= `HIVC_IMASK_RST;
			vbase_q           <= `HIVC_VBASE_RST;
			extended_mode     <= 1'b0;
			rx_enable         <= 1'b0;
			tx_enable         <= 1'b0;
			busy_q            <= 1'b0;
			data_oe           <= 1'b0;
			data_ack_strobe_n <= 1'b1;
		end else begin
			if (start) begin
				busy_q <= 1'b1;
				// the delay is loaded here, so a write to the code
				// cannot stretch or cut the cycle that carries it
				cnt_q  <= ack_delay(gcfg_q[`HIVC_ACK_HI:`HIVC_ACK_LO]);
				if ((rd_a | wr_a) && a2_q > `HIVC_LEGACY_TOP)
					extended_mode <= 1'b1;
				if (iack_a) begin
					data_out <= vec;
					data_oe  <= 1'b1;
				end else if (rd_a) begin
					data_out <= rdata;
					data_oe  <= 1'b1;
				end
				if (wr_a) begin
					case (a2_q)
					// reserved configuration bits always read zero
					`HIVC_ADDR_GCFG:  gcfg_q  <= d2_q &
						`HIVC_GCFG_MASK;
					`HIVC_ADDR_MODE:  mode_q  <= d2_q;
					`HIVC_ADDR_CSEL:  csel_q  <= d2_q;
					`HIVC_ADDR_IMASK: imask_q <= d2_q;
					`HIVC_ADDR_VBASE: vbase_q <= d2_q;
					`HIVC_ADDR_CMD: begin
						if (d2_q == `HIVC_CMD_ENABLE) begin
							rx_enable <= 1'b1;
							tx_enable <= 1'b1;
						end else begin
							rx_enable <= d2_q[`HIVC_CMD_RX_EN];
							tx_enable <= d2_q[`HIVC_CMD_TX_EN];
						end
					end
					default: ;
					endcase
				end
			end else if (busy_q) begin
				if (cnt_q > 3'd1)
					cnt_q <= cnt_q - 3'd1;
				else
					data_ack_strobe_n <= 1'b0;
				if (!active) begin
					// strobe gone: end the cycle and release the bus
					busy_q            <= 1'b0;
					data_oe           <= 1'b0;
					data_ack_strobe_n <= 1'b1;
				end
			end
		end
	end

	// mirrored settings for the channel
	// one clock of lag is harmless if they are written only with the channel off; writes are not gated by the channel enables
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_out      <= `HIVC_MODE_RST;
			clock_sel_out <= `HIVC_CSEL_RST;
			irq_mask_out  <= `HIVC_IMASK_RST;
		end else begin
			mode_out      <= mode_q;
			clock_sel_out <= csel_q;
			irq_mask_out  <= imask_q;
		end
	end
endmodule // hivc_host_port
`default_nettype wire

//--- verilog/hivc_regs.vh
`ifndef HIVC_REGS_VH
`define HIVC_REGS_VH
// ********************************************************************
// register map
// ********************************************************************
`define HIVC_ADDR_W        7
`define HIVC_LEGACY_TOP    7'h0F
`define HIVC_ADDR_GCFG     7'h66
`define HIVC_ADDR_CMD      7'h02
`define HIVC_ADDR_MODE     7'h00
`define HIVC_ADDR_CSEL     7'h01
`define HIVC_ADDR_IMASK    7'h05
`define HIVC_ADDR_VBASE    7'h0C
`define HIVC_ADDR_STAT     7'h68
// ********************************************************************
// fields and reset values
// ********************************************************************
`define HIVC_ACK_HI        7
`define HIVC_ACK_LO        6
`define HIVC_VCTL_HI       2
`define HIVC_VCTL_LO       1
`define HIVC_GCFG_RST      8'h00
`define HIVC_GCFG_MASK     8'hC6
`define HIVC_SYNC_IDLE     5'h1E
`define HIVC_MODE_RST      8'h13
`define HIVC_CSEL_RST      8'hBB
`define HIVC_IMASK_RST     8'h03
`define HIVC_VBASE_RST     8'h0F
`define HIVC_CMD_ENABLE    8'hE0
`define HIVC_CMD_RX_EN     5
`define HIVC_CMD_TX_EN     6
`define HIVC_CMD_BOTH_EN   7
`define HIVC_VCTL_NONE     2'b00
`define HIVC_VCTL_FULL     2'b01
`define HIVC_VCTL_CHAN     2'b10
`define HIVC_VCTL_TYPE     2'b11
`define HIVC_TYPE_RX_OK    2'b10
`define HIVC_TYPE_RX_ERR   2'b11
`define HIVC_TYPE_TX       2'b01
`define HIVC_TYPE_OTHER    2'b00
`define HIVC_SRC_RX        2'd1
`define HIVC_SRC_TX        2'd2
`define HIVC_ACK_D00       3'd3
`define HIVC_ACK_D01       3'd2
`define HIVC_ACK_D10       3'd1
`define HIVC_BUS_ONES      8'hFF
`endif

//--- verilog/hivc_vector.v
`timescale 1ns/1ps
`default_nettype none
`include "hivc_regs.vh"
// ********************************************************************
// interrupt vector formation
// ********************************************************************
module hivc_vector (
	input  wire [1:0] vctl,
	input  wire [7:0] vbase,
	input  wire       chan_code,
	input  wire [1:0] src,
	input  wire       rx_err,
	output reg  [7:0] vector
);
	reg [1:0] type_code;

	// type code for the modified vector
	always @* begin
		case (src)
		`HIVC_SRC_RX: type_code = rx_err ? `HIVC_TYPE_RX_ERR
			: `HIVC_TYPE_RX_OK;
		`HIVC_SRC_TX: type_code = `HIVC_TYPE_TX;
		default:      type_code = `HIVC_TYPE_OTHER;
		endcase
	end

	// vector select by control field
	always @* begin
		// except under code 00 (all ones), base bits 7:3 pass through; at most the three low bits change
		case (vctl)
		`HIVC_VCTL_NONE: vector = `HIVC_BUS_ONES;
		`HIVC_VCTL_FULL: vector = vbase;
		`HIVC_VCTL_CHAN: vector = {vbase[7:1], chan_code};
		default: vector = {vbase[7:3], type_code, chan_code};
		endcase
	end
endmodule // hivc_vector
`default_nettype wire
